//--- ssp_top.sv
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_top #(
  parameter int TOGGLE_CYC = `SSP_TOGGLE_CYC,
  parameter int ON_DELAY_CYC = `SSP_ON_DELAY_CYC,
  parameter int SPD_W = 16,
  parameter int ADC_W = 16
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic servo_on_i,
  input wire logic alarm_i,
  input wire logic warning_i,
  input wire logic battery_warning_i,
  input wire logic batteryless_enc_i,
  input wire logic torque_mode_i,
  input wire logic torque_generating_i,
  input wire logic enhanced_variant_i,
  input wire logic bus_only_variant_i,
  input wire logic signed [SPD_W-1:0] motor_speed_i,
  input wire logic [15:0] speed_limit_param_i,
  input wire logic [15:0] torque_abs_i,
  input wire logic [15:0] torque_limit_param_i,
  input wire logic [15:0] max_torque_i,
  input wire logic [15:0] max_speed_i,
  input wire logic abs_transfer_mode_i,
  input wire logic abs_bit0_i,
  input wire logic abs_bit1_i,
  input wire logic abs_ready_i,
  input wire logic pulse_permit_assigned_i,
  input wire logic pulse_permit_input_i,
  input wire logic [11:0] analog_torque_limit_i,
  input wire logic signed [ADC_W-1:0] analog_torque_command_i,
  input wire logic signed [ADC_W-1:0] analog_speed_command_i,
  input wire logic signed [ADC_W-1:0] analog_speed_limit_i,
  input wire logic forward_pulse_in_i,
  input wire logic reverse_pulse_in_i,
  output logic brake_interlock_o,
  output logic speed_limit_active_o,
  output logic zero_speed_flag_o,
  output logic torque_limit_active_o,
  output logic abs_data_bit_low_o,
  output logic abs_data_bit_high_o,
  output logic abs_data_ready_o,
  output logic fault_or_warning_o,
  output logic battery_warning_flag_o,
  output logic pulse_input_permitted_o,
  output logic general_output_a_o,
  output logic general_output_b_o,
  output logic general_output_c_o,
  output logic pulse_step_o,
  output logic pulse_dir_rev_o,
  output logic [31:0] pulse_count_o,
  output logic [15:0] torque_limit_o,
  output logic signed [16:0] torque_cmd_o,
  output logic signed [16:0] speed_cmd_o,
  output logic signed [16:0] speed_limit_o
);
  function automatic logic [15:0] mag16(input logic signed [SPD_W-1:0] v);
    logic signed [SPD_W-1:0] a;
    a = (v < 0) ? -v : v;
    return 16'(a);
  endfunction

  logic [15:0] zsp_thr_q;
  logic [31:0] pulse_cfg_q;
  logic [31:0] opt_q;
  logic [15:0] torque_fs_q;
  logic [15:0] speed_fs_q;
  logic [2:0] dout_q;
  logic [31:0] cnt_q;

  // APB: zero wait, one access cycle
  logic wr_en;
  assign wr_en = psel_i & penable_i & pwrite_i;
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      zsp_thr_q <= `SSP_ZSP_DEFAULT;
      pulse_cfg_q <= `SSP_PULSE_RST;
      opt_q <= `SSP_OPT_RST;
      torque_fs_q <= `SSP_FS_RST;
      speed_fs_q <= `SSP_FS_RST;
      dout_q <= 3'h0;
    end
    else if (wr_en)
    begin
      case (paddr_i)
        `SSP_ADDR_ZSP: zsp_thr_q <= pwdata_i[15:0];
        `SSP_ADDR_PULSE: pulse_cfg_q <= pwdata_i;
        `SSP_ADDR_OPT: opt_q <= pwdata_i;
        `SSP_ADDR_TFS: torque_fs_q <= pwdata_i[15:0];
        `SSP_ADDR_SFS: speed_fs_q <= pwdata_i[15:0];
        `SSP_ADDR_DOUT: dout_q <= pwdata_i[2:0];
        default: ;
      endcase
    end
  end

  logic known_addr;
  always_comb
  begin
    case (paddr_i)
      `SSP_ADDR_ZSP, `SSP_ADDR_PULSE, `SSP_ADDR_OPT, `SSP_ADDR_TFS, `SSP_ADDR_SFS,
      `SSP_ADDR_DOUT, `SSP_ADDR_STAT, `SSP_ADDR_PCNT, `SSP_ADDR_ANA, `SSP_ADDR_ANB: known_addr = 1'b1;
      default: known_addr = 1'b0;
    endcase
  end

  logic [31:0] rd_mux;
  always_comb
  begin
    case (paddr_i)
      `SSP_ADDR_ZSP: rd_mux = {16'h0000, zsp_thr_q};
      `SSP_ADDR_PULSE: rd_mux = pulse_cfg_q;
      `SSP_ADDR_OPT: rd_mux = opt_q;
      `SSP_ADDR_TFS: rd_mux = {16'h0000, torque_fs_q};
      `SSP_ADDR_SFS: rd_mux = {16'h0000, speed_fs_q};
      `SSP_ADDR_DOUT: rd_mux = {29'h00000000, dout_q};
      `SSP_ADDR_STAT: rd_mux = {19'h00000, general_output_c_o, general_output_b_o, general_output_a_o,
        pulse_input_permitted_o, battery_warning_flag_o, fault_or_warning_o, abs_data_ready_o,
        abs_data_bit_high_o, abs_data_bit_low_o, torque_limit_active_o, zero_speed_flag_o,
        speed_limit_active_o, brake_interlock_o};
      `SSP_ADDR_PCNT: rd_mux = cnt_q;
      `SSP_ADDR_ANA: rd_mux = {torque_limit_o[11:0], 3'h0, torque_cmd_o};
      `SSP_ADDR_ANB: rd_mux = {speed_limit_o[15:0], speed_cmd_o[15:0]};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~known_addr;
      if (psel_i & ~penable_i & ~pwrite_i)
        prdata_o <= rd_mux;
    end
  end

  // Brake, speed limit, torque limit
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      brake_interlock_o <= 1'b0;
      speed_limit_active_o <= 1'b0;
      torque_limit_active_o <= 1'b0;
    end
    else
    begin
      brake_interlock_o <= servo_on_i & ~alarm_i;
      speed_limit_active_o <= servo_on_i & torque_mode_i & ((mag16(motor_speed_i) >= speed_limit_param_i)
        | ({1'b0, mag16(motor_speed_i)} >= speed_limit_o));
      torque_limit_active_o <= servo_on_i & torque_generating_i & ~torque_mode_i
        & ((torque_abs_i >= torque_limit_param_i) | (torque_abs_i >= torque_limit_o));
    end
  end

  // Zero speed with hysteresis on magnitude
  logic [16:0] zsp_off;
  assign zsp_off = {1'b0, zsp_thr_q} + {1'b0, `SSP_ZSP_HYST};
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      zero_speed_flag_o <= 1'b0;
    else if ({1'b0, mag16(motor_speed_i)} >= zsp_off)
      zero_speed_flag_o <= 1'b0;
    else if (mag16(motor_speed_i) <= zsp_thr_q)
      zero_speed_flag_o <= 1'b1;
  end

  // Absolute position routing
  logic abs_route;
  assign abs_route = abs_transfer_mode_i & (opt_q[3:0] == `SSP_ABS_OPT_DIO);
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      abs_data_bit_low_o <= 1'b0;
      abs_data_bit_high_o <= 1'b0;
      abs_data_ready_o <= 1'b0;
    end
    else
    begin
      abs_data_bit_low_o <= abs_route & abs_bit0_i;
      abs_data_bit_high_o <= abs_route & abs_bit1_i;
      abs_data_ready_o <= abs_route & abs_ready_i;
    end
  end

  // Fault/warning output
  ssp_pkg::ssp_fw_state_t fw_q;
  logic [31:0] fw_cnt_q;
  logic other_warn;
  assign other_warn = warning_i & ~battery_warning_i;
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      fw_q <= ssp_pkg::st_boot;
      fw_cnt_q <= 32'h00000000;
      fault_or_warning_o <= 1'b0;
    end
    else
    begin
      case (fw_q)
        ssp_pkg::st_boot:
        begin
          fault_or_warning_o <= 1'b0;
          if (alarm_i)
            fw_q <= ssp_pkg::st_off;
          else if (fw_cnt_q >= 32'(ON_DELAY_CYC - 1))
          begin
            fw_q <= other_warn ? ssp_pkg::st_blink : ssp_pkg::st_on;
            fault_or_warning_o <= 1'b1;
            fw_cnt_q <= 32'h00000000;
          end
          else
            fw_cnt_q <= fw_cnt_q + 32'h00000001;
        end
        ssp_pkg::st_off:
        begin
          fault_or_warning_o <= 1'b0;
          // Stays latched off; an alarm clears only by reset
        end
        ssp_pkg::st_on:
        begin
          if (alarm_i)
          begin
            fw_q <= ssp_pkg::st_off;
            fault_or_warning_o <= 1'b0;
          end
          else if (other_warn)
          begin
            fw_q <= ssp_pkg::st_blink;
            fw_cnt_q <= 32'h00000000;
          end
          else
            fault_or_warning_o <= 1'b1;
        end
        ssp_pkg::st_blink:
        begin
          if (alarm_i)
          begin
            fw_q <= ssp_pkg::st_off;
            fault_or_warning_o <= 1'b0;
          end
          else if (!other_warn)
          begin
            fw_q <= ssp_pkg::st_on;
            fault_or_warning_o <= 1'b1;
          end
          else if (fw_cnt_q >= 32'(TOGGLE_CYC - 1))
          begin
            fault_or_warning_o <= ~fault_or_warning_o;
            fw_cnt_q <= 32'h00000000;
          end
          else
            fw_cnt_q <= fw_cnt_q + 32'h00000001;
        end
        default: fw_q <= ssp_pkg::st_boot;
      endcase
    end
  end

  // Battery flag, pulse permit, general outputs
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      battery_warning_flag_o <= 1'b0;
      pulse_input_permitted_o <= 1'b0;
      general_output_a_o <= 1'b0;
      general_output_b_o <= 1'b0;
      general_output_c_o <= 1'b0;
    end
    else
    begin
      battery_warning_flag_o <= battery_warning_i & ~batteryless_enc_i;
      pulse_input_permitted_o <= ~pulse_permit_assigned_i | pulse_permit_input_i;
      general_output_a_o <= dout_q[0] & ~bus_only_variant_i;
      general_output_b_o <= dout_q[1] & ~bus_only_variant_i;
      general_output_c_o <= dout_q[2] & ~bus_only_variant_i;
    end
  end

  // Analog inputs
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      torque_limit_o <= 16'h0000;
    else
      torque_limit_o <= ({4'h0, analog_torque_limit_i} >= max_torque_i) ? max_torque_i
        : {4'h0, analog_torque_limit_i};
  end

  logic [3:0] res_sel;
  logic signed [ADC_W-1:0] spd_cmd_q, spd_lim_q;
  assign res_sel = opt_q[7:4];
  // Low bits masked so the 14-bit mode holds the same full scale
  always_comb
  begin
    spd_cmd_q = analog_speed_command_i;
    spd_lim_q = analog_speed_limit_i;
    if (!enhanced_variant_i || res_sel == `SSP_RES_SEL_14)
    begin
      spd_cmd_q[1:0] = 2'b00;
      spd_lim_q[1:0] = 2'b00;
    end
  end

  ssp_scale #(.W(ADC_W)) u_tcmd (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .raw_i(analog_torque_command_i),
    .full_scale_i(torque_fs_q),
    .max_i(max_torque_i),
    .val_o(torque_cmd_o)
  );
  ssp_scale #(.W(ADC_W)) u_scmd (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .raw_i(spd_cmd_q),
    .full_scale_i(speed_fs_q),
    .max_i(max_speed_i),
    .val_o(speed_cmd_o)
  );
  ssp_scale #(.W(ADC_W)) u_slim (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .raw_i(spd_lim_q),
    .full_scale_i(speed_fs_q),
    .max_i(max_speed_i),
    .val_o(speed_limit_o)
  );

  // Command pulse input
  ssp_pulse_if pif();
  assign pif.fmt = pulse_cfg_q[1:0];
  assign pif.neg_logic = pulse_cfg_q[4];
  assign pif.filt = pulse_cfg_q[9:8];
  assign pif.fwd = forward_pulse_in_i;
  assign pif.rev = reverse_pulse_in_i;
  ssp_pulse_dec u_dec (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .pif(pif)
  );
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      pulse_step_o <= 1'b0;
      pulse_dir_rev_o <= 1'b0;
      cnt_q <= 32'h00000000;
      pulse_count_o <= 32'h00000000;
    end
    else
    begin
      pulse_step_o <= pif.step & pulse_input_permitted_o;
      if (pif.step & pulse_input_permitted_o)
      begin
        pulse_dir_rev_o <= pif.dir_rev;
        cnt_q <= pif.dir_rev ? cnt_q - 32'h00000001 : cnt_q + 32'h00000001;
      end
      pulse_count_o <= cnt_q;
    end
  end
endmodule

//--- ssp_map.svh
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH
`define SSP_CLK_HZ 200000000
`define SSP_ZSP_DEFAULT 16'h0032
`define SSP_ZSP_HYST 16'h0014
`define SSP_TOGGLE_MS 500
`define SSP_TOGGLE_CYC ((`SSP_CLK_HZ / 1000) * `SSP_TOGGLE_MS)
`define SSP_ON_DELAY_MS 3000
`define SSP_ON_DELAY_CYC ((`SSP_CLK_HZ / 1000) * `SSP_ON_DELAY_MS)
`define SSP_OC_RATE_HZ 200000
`define SSP_DIFF_RATE_HZ 4000000
`define SSP_FILT_OC_CYC (`SSP_CLK_HZ / `SSP_OC_RATE_HZ / 4)
`define SSP_FILT_MID_CYC (`SSP_CLK_HZ / 1000000 / 4)
`define SSP_FILT_FAST_CYC 1
`define SSP_ABS_OPT_DIO 4'h1
`define SSP_RES_SEL_14 4'h2
`define SSP_ADDR_ZSP 12'h000
`define SSP_ADDR_PULSE 12'h004
`define SSP_ADDR_OPT 12'h008
`define SSP_ADDR_TFS 12'h00c
`define SSP_ADDR_SFS 12'h010
`define SSP_ADDR_DOUT 12'h014
`define SSP_ADDR_STAT 12'h018
`define SSP_ADDR_PCNT 12'h01c
`define SSP_ADDR_ANA 12'h020
`define SSP_ADDR_ANB 12'h024
`define SSP_PULSE_RST 32'h00000000
`define SSP_OPT_RST 32'h00000000
`define SSP_FS_RST 16'hffff
`endif

//--- ssp_pkg.sv
package ssp_pkg;
  typedef enum logic [1:0] {fmt_fwd_rev, fmt_pulse_dir, fmt_quad, fmt_rsvd} ssp_fmt_t;
  typedef enum {st_boot, st_off, st_on, st_blink} ssp_fw_state_t;
endpackage

//--- ssp_pulse_if.sv
`timescale 1ns/1ps
interface ssp_pulse_if;
  logic [1:0] fmt;
  logic neg_logic;
  logic [1:0] filt;
  logic fwd;
  logic rev;
  logic step;
  logic dir_rev;
  modport dec (input fmt, input neg_logic, input filt, input fwd, input rev, output step, output dir_rev);
  modport ctl (output fmt, output neg_logic, output filt, output fwd, output rev, input step, input dir_rev);
endinterface

//--- ssp_scale.sv
`timescale 1ns/1ps
module ssp_scale #(
  parameter int W = 16
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic signed [W-1:0] raw_i,
  input wire logic [15:0] full_scale_i,
  input wire logic [15:0] max_i,
  output logic signed [16:0] val_o
);
  logic signed [W+16:0] prod;
  logic signed [16:0] sc;
  logic signed [16:0] mx;
  always_comb
  begin
    prod = raw_i * $signed({1'b0, full_scale_i});
    sc = 17'((prod + $signed((W + 17)'(1) <<< (W - 2))) >>> (W - 1));
    mx = $signed({1'b0, max_i});
    if (sc > mx)
      sc = mx;
    else if (sc < -mx)
      sc = -mx;
  end
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      val_o <= 17'h00000;
    else
      val_o <= sc;
  end
endmodule

//--- ssp_pulse_dec.sv
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_pulse_dec (
  input wire logic mclk_i,
  input wire logic rst_i,
  ssp_pulse_if.dec pif
);
  logic [1:0] filt_a_q, filt_b_q;
  logic a_q, b_q;
  logic [7:0] cnt_a_q, cnt_b_q;
  logic [7:0] lim;
  logic a_in, b_in;
  assign a_in = pif.fwd ^ pif.neg_logic;
  assign b_in = pif.rev ^ pif.neg_logic;
  always_comb
  begin
    case (pif.filt)
      2'h0: lim = 8'(`SSP_FILT_FAST_CYC);
      2'h1: lim = 8'(`SSP_FILT_MID_CYC);
      default: lim = 8'(`SSP_FILT_OC_CYC);
    endcase
  end
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      filt_a_q <= 2'h0;
      filt_b_q <= 2'h0;
      cnt_a_q <= 8'h00;
      cnt_b_q <= 8'h00;
      a_q <= 1'b0;
      b_q <= 1'b0;
    end
    else
    begin
      filt_a_q <= {filt_a_q[0], a_in};
      filt_b_q <= {filt_b_q[0], b_in};
      if (filt_a_q[1] == a_q)
        cnt_a_q <= 8'h00;
      else if (cnt_a_q + 8'h01 >= lim)
      begin
        a_q <= filt_a_q[1];
        cnt_a_q <= 8'h00;
      end
      else
        cnt_a_q <= cnt_a_q + 8'h01;
      if (filt_b_q[1] == b_q)
        cnt_b_q <= 8'h00;
      else if (cnt_b_q + 8'h01 >= lim)
      begin
        b_q <= filt_b_q[1];
        cnt_b_q <= 8'h00;
      end
      else
        cnt_b_q <= cnt_b_q + 8'h01;
    end
  end
  logic a_prev_q, b_prev_q;
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
    end
    else
    begin
      a_prev_q <= a_q;
      b_prev_q <= b_q;
    end
  end
  logic ea, eb;
  assign ea = a_q ^ a_prev_q;
  assign eb = b_q ^ b_prev_q;
  always_comb
  begin
    pif.step = 1'b0;
    pif.dir_rev = 1'b0;
    case (ssp_pkg::ssp_fmt_t'(pif.fmt))
      ssp_pkg::fmt_fwd_rev:
      begin
        // Simultaneous edges cancel rather than guess a direction
        pif.step = (a_q & ~a_prev_q) ^ (b_q & ~b_prev_q);
        pif.dir_rev = b_q & ~b_prev_q;
      end
      ssp_pkg::fmt_pulse_dir:
      begin
        pif.step = a_q & ~a_prev_q;
        pif.dir_rev = b_q;
      end
      ssp_pkg::fmt_quad:
      begin
        pif.step = ea ^ eb;
        pif.dir_rev = ea ? (a_q == b_q) : (a_q != b_q);
      end
      default:
      begin
        pif.step = 1'b0;
        pif.dir_rev = 1'b0;
      end
    endcase
  end
endmodule

//--- ssp_pulse_ctl_model.sv
`timescale 1ns/1ps
module ssp_pulse_ctl_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic dir_rev_i,
  input wire logic [7:0] count_i,
  output logic fwd_o,
  output logic rev_o,
  output logic busy_o
);
  // 25-cycle half period: exactly the 4 Mpulses/s ceiling
  localparam int HALF = 25;
  logic [7:0] left_q;
  logic [4:0] tmr_q;
  logic lvl_q;
  logic dir_q;
  assign busy_o = left_q != 8'h00;
  // Idle line stays low between trains; only one line pulses at a time
  assign fwd_o = lvl_q & ~dir_q;
  assign rev_o = lvl_q & dir_q;
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      left_q <= 8'h00;
      tmr_q <= 5'h00;
      lvl_q <= 1'b0;
      dir_q <= 1'b0;
    end
    else if (start_i && !busy_o)
    begin
      left_q <= count_i;
      dir_q <= dir_rev_i;
      tmr_q <= 5'h00;
      lvl_q <= 1'b0;
    end
    else if (busy_o)
    begin
      tmr_q <= (tmr_q == 5'(HALF - 1)) ? 5'h00 : tmr_q + 5'h01;
      if (tmr_q == 5'(HALF - 1))
      begin
        lvl_q <= ~lvl_q;
        if (lvl_q)
          left_q <= left_q - 8'h01;
      end
    end
  end
endmodule

//--- ssp_monitor.sv
`timescale 1ns/1ps
module ssp_monitor #(
  parameter int ON_DELAY_CYC = 50
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic servo_on_i,
  input wire logic alarm_i,
  input wire logic batteryless_enc_i,
  input wire logic abs_transfer_mode_i,
  input wire logic abs_ready_i,
  input wire logic pulse_permit_assigned_i,
  input wire logic [15:0] max_torque_i,
  input wire logic brake_interlock_o,
  input wire logic speed_limit_active_o,
  input wire logic fault_or_warning_o,
  input wire logic battery_warning_flag_o,
  input wire logic abs_data_ready_o,
  input wire logic pulse_input_permitted_o,
  input wire logic [15:0] torque_limit_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  int boot_q;
  // Saturates so a long run cannot wrap back into the dark window
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      boot_q <= 0;
    else if (boot_q < ON_DELAY_CYC)
      boot_q <= boot_q + 1;
  end
  brake_off_a: assert property ((!servo_on_i || alarm_i) |=> !brake_interlock_o) else $error("brake on");
  limit_off_a: assert property (!servo_on_i |=> !speed_limit_active_o) else $error("speed limit on");
  alarm_dark_a: assert property (alarm_i |=> !fault_or_warning_o [*8]) else $error("fault lit");
  boot_dark_a: assert property (fault_or_warning_o |-> boot_q >= (ON_DELAY_CYC * 5) / 6) else $error("early on");
  batt_none_a: assert property (batteryless_enc_i |=> !battery_warning_flag_o) else $error("battery flag");
  abs_gate_a: assert property (abs_data_ready_o |-> $past(abs_transfer_mode_i) && $past(abs_ready_i))
    else $error("abs ready leak");
  pulse_input_permitted_free_a: assert property (!pulse_permit_assigned_i |=> pulse_input_permitted_o) else $error("pulse_input_permitted off");
  tlim_sat_a: assert property (torque_limit_o <= $past(max_torque_i)) else $error("limit over max");
  apb_ready_a: assert property (psel_i && !penable_i |=> pready_o) else $error("no ready");
  apb_err_a: assert property (pslverr_o |-> pready_o && psel_i && penable_i) else $error("stray error");
  cover property (fault_or_warning_o);
  cover property (abs_data_ready_o);
  cover property (pslverr_o);
endmodule

//--- tb_servo_status_and_pulse_input.sv
`timescale 1ns/1ps
module tb_servo_status_and_pulse_input;
  localparam int TOG = 20;
  logic mclk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd, pulse_count_o;
  logic pready_o, pslverr_o, err, servo_on_i = 1'b0, alarm_i = 1'b0, warning_i = 1'b0;
  logic battery_warning_i = 1'b0, batteryless_enc_i = 1'b0, torque_mode_i = 1'b0, torque_generating_i = 1'b0;
  logic enhanced_variant_i = 1'b0, bus_only_variant_i = 1'b0, abs_transfer_mode_i = 1'b0;
  logic abs_bit0_i = 1'b0, abs_bit1_i = 1'b0, abs_ready_i = 1'b0, pulse_permit_assigned_i = 1'b0;
  logic pulse_permit_input_i = 1'b0, pg_start = 1'b0, pg_dir = 1'b0, pg_busy;
  logic signed [15:0] motor_speed_i = 16'sh0, analog_torque_command_i = 16'sh0;
  logic signed [15:0] analog_speed_command_i = 16'sh0, analog_speed_limit_i = 16'sh7fff;
  logic [15:0] speed_limit_param_i = 16'h01f4, torque_abs_i = 16'h0, torque_limit_param_i = 16'h012c;
  logic [15:0] max_torque_i = 16'h03e8, max_speed_i = 16'h09c4, torque_limit_o;
  logic [11:0] analog_torque_limit_i = 12'hfff;
  logic [7:0] pg_cnt = 8'h00;
  wire forward_pulse_in_i, reverse_pulse_in_i;
  logic brake_interlock_o, speed_limit_active_o, zero_speed_flag_o, torque_limit_active_o, abs_data_bit_low_o;
  logic abs_data_bit_high_o, abs_data_ready_o, fault_or_warning_o, battery_warning_flag_o, pulse_input_permitted_o;
  logic general_output_a_o, general_output_b_o, general_output_c_o, pulse_step_o, pulse_dir_rev_o;
  logic signed [16:0] torque_cmd_o, speed_cmd_o, speed_limit_o;
  logic signed [15:0] zsv [7] = '{16'sh0045, 16'sh0046, 16'sh0033, 16'sh0032, -16'sh0045, -16'sh0046, -16'sh0032};
  logic [6:0] zex = 7'b1001101;
  int miscompares = 0;
  int total_checks = 0;
  int n;
  ssp_top #(.TOGGLE_CYC(TOG), .ON_DELAY_CYC(50)) DUT (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .servo_on_i, .alarm_i, .warning_i, .battery_warning_i,
    .batteryless_enc_i, .torque_mode_i, .torque_generating_i, .enhanced_variant_i, .bus_only_variant_i,
    .motor_speed_i, .speed_limit_param_i, .torque_abs_i, .torque_limit_param_i, .max_torque_i, .max_speed_i,
    .abs_transfer_mode_i, .abs_bit0_i, .abs_bit1_i, .abs_ready_i, .pulse_permit_assigned_i, .pulse_permit_input_i,
    .analog_torque_limit_i, .analog_torque_command_i, .analog_speed_command_i, .analog_speed_limit_i,
    .forward_pulse_in_i, .reverse_pulse_in_i, .brake_interlock_o, .speed_limit_active_o, .zero_speed_flag_o,
    .torque_limit_active_o, .abs_data_bit_low_o, .abs_data_bit_high_o, .abs_data_ready_o, .fault_or_warning_o,
    .battery_warning_flag_o, .pulse_input_permitted_o, .general_output_a_o, .general_output_b_o,
    .general_output_c_o, .pulse_step_o, .pulse_dir_rev_o, .pulse_count_o, .torque_limit_o, .torque_cmd_o,
    .speed_cmd_o, .speed_limit_o);
  ssp_pulse_ctl_model PCTL (.mclk_i, .rst_i, .start_i(pg_start), .dir_rev_i(pg_dir), .count_i(pg_cnt),
    .fwd_o(forward_pulse_in_i), .rev_o(reverse_pulse_in_i), .busy_o(pg_busy));
  initial
  begin
    forever #2.5 mclk_i = ~mclk_i;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask
  // Holds the request until pready is seen high at a rising edge, then releases
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge mclk_i);
      if (pready_o === 1'b1)
        break;
    end
    if (k == 50)
      chk("pready_o", 32'h1, 32'h0);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic pulses(input logic dir, input logic [7:0] c);
    @(posedge mclk_i);
    pg_dir <= dir;
    pg_cnt <= c;
    pg_start <= 1'b1;
    @(posedge mclk_i);
    pg_start <= 1'b0;
    @(negedge mclk_i);
    for (n = 0; n < 2000 && pg_busy !== 1'b0; n++)
      @(negedge mclk_i);
    wt(30);
  endtask
  task automatic edges(input int lim);
    logic last;
    last = fault_or_warning_o;
    for (n = 0; n < lim && fault_or_warning_o === last; n++)
      @(negedge mclk_i);
  endtask
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    miscompares++;
    conclude();
  end
  initial
  begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    wt(38);
    chk("fault_early", 32'h0, fault_or_warning_o);
    wt(16);
    chk("fault_late", 32'h1, fault_or_warning_o);
    rdc("zero_thr", 12'h000, 32'h32);
    rdc("torque_fs", 12'h00c, 32'hffff);
    apb(1'b0, 12'h0f0, 32'h0);
    chk("unmapped_err", 32'h1, err);
    chk("unmapped_rd", 32'h0, rd);
    for (int i = 0; i < 7; i++)
    begin
      @(posedge mclk_i);
      motor_speed_i <= zsv[i];
      wt(3);
      chk("zero_speed", zex[6 - i], zero_speed_flag_o);
    end
    apb(1'b1, 12'h000, 32'h64);
    @(posedge mclk_i);
    motor_speed_i <= 16'sh0077;
    wt(3);
    chk("zero_speed_thr", 32'h1, zero_speed_flag_o);
    @(posedge mclk_i);
    motor_speed_i <= 16'sh0078;
    servo_on_i <= 1'b1;
    torque_generating_i <= 1'b1;
    torque_abs_i <= 16'h0190;
    wt(3);
    chk("zero_speed_rel", 32'h0, zero_speed_flag_o);
    chk("brake_on", 32'h1, brake_interlock_o);
    chk("torque_lim_hi", 32'h1, torque_limit_active_o);
    chk("torque_limit", 32'h3e8, torque_limit_o);
    @(posedge mclk_i);
    motor_speed_i <= -16'sh0258;
    torque_mode_i <= 1'b1;
    torque_abs_i <= 16'h00c8;
    wt(3);
    chk("speed_lim_hi", 32'h1, speed_limit_active_o);
    chk("torque_lim_lo", 32'h0, torque_limit_active_o);
    @(posedge mclk_i);
    servo_on_i <= 1'b0;
    wt(3);
    chk("speed_lim_off", 32'h0, speed_limit_active_o);
    apb(1'b1, 12'h00c, 32'h320);
    apb(1'b1, 12'h010, 32'hbb8);
    @(posedge mclk_i);
    analog_torque_command_i <= -16'sh7fff;
    analog_speed_command_i <= 16'sh7fff;
    wt(3);
    chk("torque_cmd", 32'hfffffce0, 32'(torque_cmd_o));
    chk("speed_cmd_clamp", 32'h9c4, 32'(speed_cmd_o));
    chk("speed_lim_clamp", 32'h9c4, 32'(speed_limit_o));
    apb(1'b1, 12'h00c, 32'h7d0);
    apb(1'b1, 12'h010, 32'h7d0);
    @(posedge mclk_i);
    analog_torque_command_i <= 16'sh7fff;
    analog_speed_command_i <= -16'sh7fff;
    wt(3);
    chk("torque_cmd_clamp", 32'h3e8, 32'(torque_cmd_o));
    chk("speed_cmd", 32'hfffff830, 32'(speed_cmd_o));
    chk("speed_lim", 32'h7d0, 32'(speed_limit_o));
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, 12'h008, 32'(i));
      @(posedge mclk_i);
      abs_transfer_mode_i <= 1'b1;
      abs_bit0_i <= 1'b1;
      abs_bit1_i <= 1'b1;
      abs_ready_i <= 1'b1;
      wt(3);
      chk("abs_ready", 32'(i), abs_data_ready_o);
      chk("abs_bits", 32'(i * 3), {abs_data_bit_high_o, abs_data_bit_low_o});
    end
    @(posedge mclk_i);
    abs_transfer_mode_i <= 1'b0;
    wt(3);
    chk("abs_out_mode", 32'h0, abs_data_ready_o);
    for (int i = 2; i < 6; i += 3)
    begin
      apb(1'b1, 12'h014, 32'(i));
      wt(2);
      chk("gen_out", 32'(i), {general_output_c_o, general_output_b_o, general_output_a_o});
    end
    apb(1'b1, 12'h004, 32'h0);
    chk("pulse_input_permitted", 32'h1, pulse_input_permitted_o);
    pulses(1'b0, 8'h05);
    chk("count_fwd", 32'h5, pulse_count_o);
    pulses(1'b1, 8'h03);
    chk("count_rev", 32'h2, pulse_count_o);
    chk("dir_rev", 32'h1, pulse_dir_rev_o);
    rdc("count_reg", 12'h01c, 32'h2);
    @(posedge mclk_i);
    warning_i <= 1'b1;
    edges(100);
    edges(100);
    chk("blink_half", 32'(TOG), n);
    @(posedge mclk_i);
    battery_warning_i <= 1'b1;
    wt(TOG + 3);
    edges(50);
    chk("batt_steady", 32'd50, n);
    chk("batt_flag", 32'h1, battery_warning_flag_o);
    @(posedge mclk_i);
    batteryless_enc_i <= 1'b1;
    servo_on_i <= 1'b1;
    wt(3);
    chk("batt_less", 32'h0, battery_warning_flag_o);
    @(posedge mclk_i);
    alarm_i <= 1'b1;
    wt(3);
    chk("alarm_fault", 32'h0, fault_or_warning_o);
    chk("alarm_brake", 32'h0, brake_interlock_o);
    conclude();
  end
endmodule
bind ssp_top ssp_monitor #(.ON_DELAY_CYC(ON_DELAY_CYC)) u_mon (.mclk_i, .rst_i, .psel_i, .penable_i, .pready_o,
  .pslverr_o, .servo_on_i, .alarm_i, .batteryless_enc_i, .abs_transfer_mode_i, .abs_ready_i, .pulse_permit_assigned_i,
  .max_torque_i, .brake_interlock_o, .speed_limit_active_o, .fault_or_warning_o, .battery_warning_flag_o,
  .abs_data_ready_o, .pulse_input_permitted_o, .torque_limit_o);
